/* design/cfsc_defines.vh */
`ifndef CFSC_DEFINES_VH
`define CFSC_DEFINES_VH
// Register byte offsets
`define CFSC_CTRL_OFF      12'h000
`define CFSC_AUTO_OFF      12'h004
`define CFSC_MAN_OFF       12'h008
`define CFSC_TEMP_OFF      12'h00C
`define CFSC_SPEED_OFF     12'h010
`define CFSC_STAT_OFF      12'h014
// Mode encodings
`define CFSC_MODE_FULL     2'h0
`define CFSC_MODE_AUTO     2'h1
`define CFSC_MODE_MAN      2'h2
// Auto register field positions
`define CFSC_STOP_LSB      0
`define CFSC_START_LSB     8
`define CFSC_INIT_LSB      16
`define CFSC_SLOPE_LSB     24
// Reset values
`define CFSC_STOP_RST      7'h00
`define CFSC_START_RST     7'h14
`define CFSC_INIT_RST      7'h46
`define CFSC_SLOPE_RST     3'h1
`define CFSC_MAN_RST       7'h00
`define CFSC_DUTY_MAX      7'h7F
// Timing: PWM prescaler 125 MHz / 40 / 127 phase steps ~ 24.6 kHz
`define CFSC_PWM_DIV       6'h27
// Tach gate: 1 s window, count edges (2 pulses per revolution)
`define CFSC_GATE_NS       1000000000
`define CFSC_CLK_NS        8
`define CFSC_GATE_CYC      (`CFSC_GATE_NS / `CFSC_CLK_NS)
`endif

/* design/cfsc_tach.v */
`timescale 1ns/10ps
// Tachometer: counts rising edges in a gate window, RPM = pulses*30 at 1 s gate
module cfsc_tach (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        gate,
  input  wire        tach,
  output reg  [15:0] rpm_r
);
  reg        tach_d_r;
  reg [15:0] cnt_r;
  wire       edge_w = tach & ~tach_d_r;
  // Edge counter, dumped and rescaled at each gate pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tach_d_r <= 1'b0;
      cnt_r    <= 16'h0000;
      rpm_r    <= 16'h0000;
    end else begin
      tach_d_r <= tach;
      if (gate) begin
        rpm_r <= (cnt_r[15:11] != 5'h00) ? 16'hFFFF : cnt_r * 16'h001E;
        cnt_r <= {15'h0000, edge_w};
      end else if (edge_w && cnt_r != 16'hFFFF) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end
endmodule // cfsc_tach

/* design/cfsc_ctrl.v */
`timescale 1ns/10ps
`include "cfsc_defines.vh"
// Function
// R1: Full-on mode drives fan always on; mode resets to full-on.
// R2: Auto mode turns fan off when temperature falls to stop threshold.
// R3: Auto mode starts fan above start threshold at initial duty.
// R4: Thresholds are unsigned 0..127 degrees Celsius.
// R5: 128 duty levels 0..127 for initial and manual duty.
// R6: Auto duty rises linearly with slope 0,1,2,4,8,16,32,64.
// R7: Manual mode drives the written duty, ignoring thresholds and slope.
// R8: Defaults stop 0, start 20, initial duty 70, slope 1.
// R9: Auto parameters writable only in auto; manual duty only in manual.
// R10: Temperatures and fan speeds in RPM readable by firmware.
// R11: Auto duty = initial + slope*(temp-start), saturating at 127.
// R12: Between thresholds fan keeps previous on/off state.
module cfsc_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [6:0]  cpu_temp,
  input  wire [6:0]  sys_temp,
  input  wire        cpu_tach,
  input  wire        sys_tach,
  output reg         fan_pwm
);
  reg  [1:0]  mode_r;
  reg  [6:0]  stop_r;
  reg  [6:0]  start_r;
  reg  [6:0]  init_r;
  reg  [2:0]  slope_r;
  reg  [6:0]  man_r;
  reg         fan_on_r;
  reg  [6:0]  duty_r;
  reg  [6:0]  duty_nxt;
  reg  [5:0]  div_r;
  reg  [6:0]  phase_r;
  reg  [26:0] gate_r;
  reg         gate_r_p;
  wire [15:0] cpu_rpm;
  wire [15:0] sys_rpm;

  // Address match helper used by read and write decode
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // Slope code to levels per degree: 0 then powers of two
  function [7:0] slope_lv;
    input [2:0] s;
    begin
      slope_lv = (s == 3'h0) ? 8'h00 : (8'h01 << (s - 3'h1)); // R6
    end
  endfunction

  wire acc  = psel & penable;
  wire wr   = acc & pwrite;
  wire bad  = !(hit(paddr, `CFSC_CTRL_OFF) || hit(paddr, `CFSC_AUTO_OFF) ||
                hit(paddr, `CFSC_MAN_OFF) || hit(paddr, `CFSC_TEMP_OFF) ||
                hit(paddr, `CFSC_SPEED_OFF) || hit(paddr, `CFSC_STAT_OFF));

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: single-cycle access phase, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & bad;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (hit(paddr, `CFSC_CTRL_OFF))
          prdata <= {30'h0000_0000, mode_r};
        else if (hit(paddr, `CFSC_AUTO_OFF))
          prdata <= {5'h00, slope_r, 1'b0, init_r, 1'b0, start_r, 1'b0, stop_r};
        else if (hit(paddr, `CFSC_MAN_OFF))
          prdata <= {25'h000_0000, man_r};
        else if (hit(paddr, `CFSC_TEMP_OFF))
          prdata <= {9'h000, sys_temp, 9'h000, cpu_temp}; // R10
        else if (hit(paddr, `CFSC_SPEED_OFF))
          prdata <= {sys_rpm, cpu_rpm}; // R10
        else if (hit(paddr, `CFSC_STAT_OFF))
          prdata <= {23'h00_0000, fan_on_r, 1'b0, duty_r}; // R10
      end
    end
  end

  // Registers; writes land in the cycle pready is high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r  <= `CFSC_MODE_FULL; // R1
      stop_r  <= `CFSC_STOP_RST; // R8
      start_r <= `CFSC_START_RST; // R8
      init_r  <= `CFSC_INIT_RST; // R8
      slope_r <= `CFSC_SLOPE_RST; // R8
      man_r   <= `CFSC_MAN_RST;
    end else if (wr && pready) begin
      if (hit(paddr, `CFSC_CTRL_OFF) && pwdata[1:0] != 2'h3)
        mode_r <= pwdata[1:0]; // Code 3 is ignored, mode stays valid
      if (hit(paddr, `CFSC_AUTO_OFF) && mode_r == `CFSC_MODE_AUTO) begin // R9
        stop_r  <= pwdata[`CFSC_STOP_LSB +: 7]; // R4
        start_r <= pwdata[`CFSC_START_LSB +: 7]; // R4
        init_r  <= pwdata[`CFSC_INIT_LSB +: 7]; // R5
        slope_r <= pwdata[`CFSC_SLOPE_LSB +: 3];
      end
      if (hit(paddr, `CFSC_MAN_OFF) && mode_r == `CFSC_MODE_MAN) // R9
        man_r <= pwdata[6:0]; // R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Duty selection per mode
  wire [6:0]  above = (cpu_temp > start_r) ? (cpu_temp - start_r) : 7'h00;
  wire [14:0] rise  = above * slope_lv(slope_r);
  wire [15:0] sum   = {9'h000, init_r} + {1'b0, rise};
  always @* begin
    case (mode_r)
      `CFSC_MODE_FULL: duty_nxt = `CFSC_DUTY_MAX; // R1
      `CFSC_MODE_AUTO: duty_nxt = !fan_on_r ? 7'h00 : // R2
                         (sum > 16'h007F) ? `CFSC_DUTY_MAX : sum[6:0]; // R11 R3
      `CFSC_MODE_MAN:  duty_nxt = man_r; // R7
      default:         duty_nxt = `CFSC_DUTY_MAX;
    endcase
  end

  // On/off state with hysteresis; held between the two thresholds
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fan_on_r <= 1'b1;
      duty_r   <= `CFSC_DUTY_MAX;
    end else begin
      if (mode_r != `CFSC_MODE_AUTO)
        fan_on_r <= 1'b1;
      else if (cpu_temp <= stop_r)
        fan_on_r <= 1'b0; // R2
      else if (cpu_temp > start_r)
        fan_on_r <= 1'b1; // R3 R12
      duty_r <= duty_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM: prescaled phase counter, 127 gives continuous high
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r   <= 6'h00;
      phase_r <= 7'h00;
      fan_pwm <= 1'b0;
    end else begin
      if (div_r == `CFSC_PWM_DIV) begin
        div_r   <= 6'h00;
        phase_r <= (phase_r == 7'h7E) ? 7'h00 : phase_r + 7'h01;
      end else begin
        div_r <= div_r + 6'h01;
      end
      fan_pwm <= (duty_r == `CFSC_DUTY_MAX) | (phase_r < duty_r); // R1 R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tach gate pulse; long window, one-cycle enable
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r   <= 27'h000_0000;
      gate_r_p <= 1'b0;
    end else begin
      gate_r_p <= (gate_r == `CFSC_GATE_CYC - 1);
      gate_r   <= (gate_r == `CFSC_GATE_CYC - 1) ? 27'h000_0000 : gate_r + 27'h000_0001;
    end
  end

  // Speed measurement of both fans
  cfsc_tach u_cpu_tach (
    .pclk    (pclk),
    .presetn (presetn),
    .gate    (gate_r_p),
    .tach    (cpu_tach),
    .rpm_r   (cpu_rpm)
  ); // R10
  cfsc_tach u_sys_tach (
    .pclk    (pclk),
    .presetn (presetn),
    .gate    (gate_r_p),
    .tach    (sys_tach),
    .rpm_r   (sys_rpm)
  );
endmodule // cfsc_ctrl

/* tb/cfsc_checker.sv */
`timescale 1ns/10ps
// Watches the APB slave and the fan output of the controller
module cfsc_checker (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        fan_pwm
);
  reg  [1:0] mode_r;
  reg  [6:0] man_r;
  reg  [1:0] quiet_r;
  wire       wr = psel & penable & pready & pwrite;
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of mode and manual duty; quiet waits out the two-cycle duty lag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= 2'h0;
      man_r <= 7'h00;
      quiet_r <= 2'h0;
    end else begin
      if (wr && paddr == 12'h000 && pwdata[1:0] != 2'h3) mode_r <= pwdata[1:0];
      if (wr && paddr == 12'h008 && mode_r == 2'h2) man_r <= pwdata[6:0];
      quiet_r <= wr ? 2'h0 : (quiet_r == 2'h3 ? 2'h3 : quiet_r + 2'h1);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
  a_unmapped_err: assert property (psel && !penable && paddr > 12'h014 |=> pslverr)
    else $error("no error");
  a_mapped_ok: assert property (psel && !penable && paddr[1:0] == 2'h0 && paddr <= 12'h014
    |=> !pslverr) else $error("bad error");
  a_full_on: assert property (quiet_r == 2'h3 && mode_r == 2'h0 |-> fan_pwm)
    else $error("fan not on");
  a_manual_off: assert property (quiet_r == 2'h3 && mode_r == 2'h2 && man_r == 7'h00
    |-> !fan_pwm) else $error("fan not off");
  a_manual_max: assert property (quiet_r == 2'h3 && mode_r == 2'h2 && man_r == 7'h7F
    |-> fan_pwm) else $error("fan not full");
  a_mode_read: assert property (psel && !penable && !pwrite && paddr == 12'h000
    |=> prdata[1:0] == mode_r) else $error("mode read");
endmodule // cfsc_checker

/* tb/cfsc_fan_model.sv */
`timescale 1ns/10ps
// Sensor and fan stand-in; the rotor only turns while the fan is driven
module cfsc_fan_model (
  input  wire       pclk,
  input  wire [6:0] temp_set,
  input  wire       fan_pwm,
  output reg  [6:0] cpu_temp = 7'h00,
  output reg  [6:0] sys_temp = 7'h00,
  output wire       cpu_tach,
  output wire       sys_tach
);
  reg [3:0] rot_r = 4'h0;
  // Board sensor reads a little warmer than the processor
  always @(posedge pclk) begin
    cpu_temp <= temp_set;
    sys_temp <= temp_set + 7'h05;
    if (fan_pwm) rot_r <= rot_r + 4'h1;
  end
  assign cpu_tach = rot_r[3];
  assign sys_tach = rot_r[2];
endmodule // cfsc_fan_model

/* tb/tb_cpu_fan_speed_control.sv */
`timescale 1ns/10ps
`define CHK(n,e,s) begin cmp_count++; if ((e) !== (s)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_cpu_fan_speed_control;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg  [6:0]  temp_set = 7'h19;
  reg  [31:0] q;
  reg         e;
  wire [31:0] prdata;
  wire        pready, pslverr, cpu_tach, sys_tach, fan_pwm;
  wire [6:0]  cpu_temp, sys_temp;
  integer     n_errors = 0;
  integer     cmp_count = 0;
  integer     cyc = 0;
  integer     i;
  cfsc_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_temp(cpu_temp), .sys_temp(sys_temp), .cpu_tach(cpu_tach),
    .sys_tach(sys_tach), .fan_pwm(fan_pwm));
  cfsc_fan_model fan (.pclk(pclk), .temp_set(temp_set), .fan_pwm(fan_pwm),
    .cpu_temp(cpu_temp), .sys_temp(sys_temp), .cpu_tach(cpu_tach), .sys_tach(sys_tach));
  always #4 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer, held until pready is sampled high
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Set a temperature, let the duty settle, compare fan state and duty
  task heat(input [6:0] t, input [8:0] x, input [8:0] m);
    begin
      temp_set <= t;
      repeat (4) @(posedge pclk);
      apb(1'b0, 12'h014, 32'h0000_0000);
      `CHK("stat", x & m, q[8:0] & m)
    end
  endtask
  task close_out;
    begin
      $display("mismatches %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset defaults, then writes refused outside their own mode
  task t_manual;
    begin
      apb(1'b0, 12'h000, 32'h0000_0000);
      `CHK("mode", 2'h0, q[1:0])
      apb(1'b1, 12'h008, 32'h0000_0055);
      apb(1'b1, 12'h000, 32'h0000_0002);
      apb(1'b1, 12'h004, 32'h0000_0000);
      apb(1'b0, 12'h004, 32'h0000_0000);
      `CHK("auto", 32'h0146_1400, q & 32'h077F_7F7F)
      apb(1'b0, 12'h008, 32'h0000_0000);
      `CHK("man", 7'h00, q[6:0])
      repeat (3) @(posedge pclk);
      `CHK("fan", 1'b0, fan_pwm)
      apb(1'b1, 12'h008, 32'h0000_007F);
      heat(7'h19, 9'h17F, 9'h1FF);
    end
  endtask
  // Automatic mode: start, hold band, stop, every slope, saturation
  task t_auto;
    begin
      apb(1'b1, 12'h000, 32'h0000_0001);
      apb(1'b1, 12'h004, 32'h020A_281E);
      heat(7'h32, 9'h11E, 9'h1FF);
      heat(7'h23, 9'h100, 9'h100);
      heat(7'h1E, 9'h000, 9'h100);
      heat(7'h23, 9'h000, 9'h100);
      for (i = 0; i < 8; i = i + 1) begin
        apb(1'b1, 12'h004, {5'h00, i[2:0], 24'h0A_281E});
        heat(7'h29, 9'h10A + (i == 0 ? 9'h000 : 9'h001 << (i - 1)), 9'h1FF);
      end
      heat(7'h7F, 9'h17F, 9'h1FF);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      `CHK("temp", {7'h04, 7'h7F}, {q[22:16], q[6:0]})
      // No one-second gate window has closed yet, so both speeds still read zero
      apb(1'b0, 12'h010, 32'h0000_0000);
      `CHK("speed", 32'h0000_0000, q)
      apb(1'b1, 12'h000, 32'h0000_0000);
      heat(7'h00, 9'h17F, 9'h1FF);
      // Mode code 3 is not a mode; the write must leave full-on in place
      apb(1'b1, 12'h000, 32'h0000_0003);
      apb(1'b0, 12'h000, 32'h0000_0000);
      `CHK("mode3", 2'h0, q[1:0])
      apb(1'b0, 12'h018, 32'h0000_0000);
      `CHK("err", 1'b1, e)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard: the run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      close_out;
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_manual;
    t_auto;
    close_out;
  end
endmodule // tb_cpu_fan_speed_control
bind cfsc_ctrl cfsc_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fan_pwm(fan_pwm));
